// ==== common/drive_cmd_pkg.sv ====
package drive_cmd_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_TIME_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int BOOT_WAIT_MS = 1000;
  localparam int BOOT_CYCLES = CLK_HZ / 1000 * BOOT_WAIT_MS;

  // ----------------------------------------
  // register word offsets
  // ----------------------------------------
  localparam logic [3:0] REG_BRAKE = 4'h0;
  localparam logic [3:0] REG_ALARM = 4'h1;
  localparam logic [3:0] REG_MOTION = 4'h2;
  localparam logic [3:0] REG_RATE = 4'h3;
  localparam logic [3:0] REG_QUEUE = 4'h4;
  localparam logic [3:0] REG_RUN_CUR = 4'h5;
  localparam logic [3:0] REG_ACC_CUR = 4'h6;
  localparam logic [3:0] REG_MODE = 4'h7;
  localparam logic [3:0] REG_ENABLE = 4'h8;
  localparam logic [3:0] REG_DELAY = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'ha;
  localparam logic [3:0] REG_OWNER = 4'hb;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BRAKE_PT_LSB = 4;
  localparam int QUEUE_OVF_BIT = 8;
  localparam int MODE_PM_BIT = 8;
  localparam int EN_MOTOR_BIT = 1;
  localparam int EN_MOVE_BIT = 2;
  localparam int DLY_APPLY_LSB = 16;
  localparam int STAT_BOOT_BIT = 4;
  localparam int STAT_REJ_BIT = 5;

  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [1:0] USE_CLOSED_EN = 2'h1;
  localparam logic [1:0] USE_OPEN_EN = 2'h2;
  localparam logic [1:0] USE_RELEASED = 2'h3;
  localparam logic [2:0] RST_BRAKE_PT = 3'h1;
  localparam logic [2:0] RATE_BOOT = 3'h1;
  localparam logic [2:0] RATE_LAST = 3'h5;
  localparam logic [4:0] MODE_STEP_DIR = 5'h07;
  localparam logic [4:0] RST_MODE = 5'h00;
  localparam logic [9:0] RST_CURRENT = 10'h000;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam int QUEUE_DEPTH = 63;
  localparam int IO_POINTS = 4;

  typedef enum logic [2:0] {OWN_GP, OWN_ALARM, OWN_BRAKE, OWN_MOTION, OWN_TACH} own_e;
  typedef enum logic [1:0] {DS_OFF, DS_RELEASE, DS_ON, DS_APPLY} drive_e;

  // bit period in clock cycles for each rate code
  function automatic logic [15:0] rate_div(input logic [2:0] code);
    case (code)
      3'h2: rate_div = 16'(CLK_HZ / 19200);
      3'h3: rate_div = 16'(CLK_HZ / 38400);
      3'h4: rate_div = 16'(CLK_HZ / 57600);
      3'h5: rate_div = 16'(CLK_HZ / 115200);
      default: rate_div = 16'(CLK_HZ / 9600);
    endcase
  endfunction

endpackage

// ==== logic/bit_rate_gen.sv ====
`timescale 1ns/1ns
module bit_rate_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // rate control
  input wire logic [2:0] rate_code,
  input wire logic restart,
  // one-cycle enable per serial bit
  output logic bit_tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } gen_s;

  gen_s s;
  gen_s n;

  // count down one bit period, restart on a rate change
  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (restart || s.cnt == 16'h0000) begin
      n.cnt = drive_cmd_pkg::rate_div(rate_code) - 16'h0001;
      n.tick = !restart;
    end else begin
      n.cnt = s.cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bit_tick = s.tick;

endmodule

// ==== logic/drive_cmd_regs.sv ====
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module drive_cmd_regs #(
  parameter bit VARIABLE_IO = 1'b1,
  parameter int MS_CYCLES = drive_cmd_pkg::MS_CYCLES,
  parameter int BOOT_CYCLES = drive_cmd_pkg::BOOT_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // stored settings and host link
  input wire logic [2:0] nv_rate_code,
  input wire logic nv_pm_lang,
  input wire logic host_seen,
  output logic nv_store,
  output logic session_drop,
  output logic bit_tick,
  // command queue
  input wire logic queue_push,
  input wire logic queue_pop,
  // digital outputs, low is closed
  input wire logic [3:0] io_is_output,
  output logic [3:0] out_pin_b,
  // motor
  output logic motor_on,
  output logic move_ok,
  output logic [9:0] accel_cur_eff
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] usage;
    logic [2:0] brake_pt;
    logic [3:0][2:0] owner;
    logic [2:0] rate_stored;
    logic [2:0] rate_active;
    logic loaded;
    logic boot_done;
    logic [31:0] boot_cnt;
    logic [31:0] ms_cnt;
    logic [15:0] dly;
    logic [15:0] rel_dly;
    logic [15:0] app_dly;
    logic [9:0] run_cur;
    logic [9:0] acc_cur;
    logic acc_rej;
    logic [4:0] mode;
    logic pm_lang;
    logic en_req;
    drive_cmd_pkg::drive_e dstate;
    logic [5:0] occ;
    logic ovf;
    logic wait_q;
    logic [31:0] rdata;
    logic [3:0] pin_b;
    logic motor;
    logic move;
    logic [9:0] cur_eff;
    logic drop;
    logic store;
  } regs_s;

  regs_s s;
  regs_s n;
  logic [31:0] rd_val;
  logic [31:0] wd;
  logic wr_go;
  logic push_ok;
  logic ms_tick;
  logic brake_on;
  logic en_view;
  // zero delay when the brake is released, so the drive steps straight through
  localparam logic [15:0] RST_DLY_ZERO = drive_cmd_pkg::RST_DELAY;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic point_ok(input logic [2:0] p);
    point_ok = (p >= 3'h1) && (p <= 3'(drive_cmd_pkg::IO_POINTS));
  endfunction

  function automatic logic rate_ok(input logic [2:0] c);
    rate_ok = (c >= drive_cmd_pkg::RATE_BOOT) && (c <= drive_cmd_pkg::RATE_LAST);
  endfunction

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (address[5:2])
      drive_cmd_pkg::REG_BRAKE: begin
        rd_val[1:0] = s.usage;
        rd_val[drive_cmd_pkg::BRAKE_PT_LSB +: 3] = s.brake_pt;
      end
      drive_cmd_pkg::REG_RATE: rd_val[2:0] = s.rate_stored;
      drive_cmd_pkg::REG_QUEUE: begin
        rd_val[5:0] = 6'(drive_cmd_pkg::QUEUE_DEPTH) - s.occ;
        rd_val[drive_cmd_pkg::QUEUE_OVF_BIT] = s.ovf;
      end
      drive_cmd_pkg::REG_RUN_CUR: rd_val[9:0] = s.run_cur;
      drive_cmd_pkg::REG_ACC_CUR: rd_val[9:0] = s.acc_cur;
      drive_cmd_pkg::REG_MODE: begin
        rd_val[4:0] = s.mode;
        rd_val[drive_cmd_pkg::MODE_PM_BIT] = s.pm_lang;
      end
      drive_cmd_pkg::REG_ENABLE: begin
        rd_val[0] = s.en_req;
        rd_val[drive_cmd_pkg::EN_MOTOR_BIT] = s.motor;
        rd_val[drive_cmd_pkg::EN_MOVE_BIT] = s.move;
      end
      drive_cmd_pkg::REG_DELAY: begin
        rd_val[15:0] = s.rel_dly;
        rd_val[drive_cmd_pkg::DLY_APPLY_LSB +: 16] = s.app_dly;
      end
      drive_cmd_pkg::REG_STATUS: begin
        rd_val[2:0] = s.rate_active;
        rd_val[drive_cmd_pkg::STAT_BOOT_BIT] = s.boot_done;
        rd_val[drive_cmd_pkg::STAT_REJ_BIT] = s.acc_rej;
      end
      drive_cmd_pkg::REG_OWNER: rd_val[11:0] = s.owner;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // byte lanes not enabled keep their present value
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wd[8*b +: 8] = byteenable[b] ? writedata[8*b +: 8] : rd_val[8*b +: 8];
    end
  end

  assign wr_go = write && !s.wait_q;
  assign ms_tick = (s.ms_cnt == 32'(MS_CYCLES - 1));
  assign push_ok = queue_push && (s.occ != 6'(drive_cmd_pkg::QUEUE_DEPTH));

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    n.drop = 1'b0;
    n.store = 1'b0;
    brake_on = 1'b0;
    en_view = 1'b0;

    // one wait cycle, then the answer stands with waitrequest low
    n.wait_q = !((read || write) && s.wait_q);
    if (read && s.wait_q) begin
      n.rdata = rd_val;
    end

    // bus writes go first so hardware events below win over clears
    if (wr_go) begin
      unique case (address[5:2])
        drive_cmd_pkg::REG_BRAKE: begin
          if (wd[1:0] == drive_cmd_pkg::USE_CLOSED_EN ||
              wd[1:0] == drive_cmd_pkg::USE_OPEN_EN) begin
            if (VARIABLE_IO == 1'b0 || point_ok(wd[drive_cmd_pkg::BRAKE_PT_LSB +: 3])) begin
              if (s.usage != drive_cmd_pkg::USE_RELEASED) begin
                n.owner[s.brake_pt - 3'h1] = drive_cmd_pkg::OWN_GP;
              end
              n.brake_pt = VARIABLE_IO ? wd[drive_cmd_pkg::BRAKE_PT_LSB +: 3]
                                       : drive_cmd_pkg::RST_BRAKE_PT;
              n.owner[n.brake_pt - 3'h1] = drive_cmd_pkg::OWN_BRAKE;
              n.usage = wd[1:0];
              n.store = 1'b1;
            end
          end else if (wd[1:0] == drive_cmd_pkg::USE_RELEASED) begin
            if (s.usage != drive_cmd_pkg::USE_RELEASED) begin
              n.owner[s.brake_pt - 3'h1] = drive_cmd_pkg::OWN_GP;
            end
            n.usage = drive_cmd_pkg::USE_RELEASED;
            n.store = 1'b1;
          end
          // code 0 is not a usage code and leaves everything alone
        end
        drive_cmd_pkg::REG_ALARM, drive_cmd_pkg::REG_MOTION: begin
          if (point_ok(wd[2:0])) begin
            for (int i = 0; i < drive_cmd_pkg::IO_POINTS; i++) begin
              if (address[5:2] == drive_cmd_pkg::REG_ALARM &&
                  s.owner[i] == drive_cmd_pkg::OWN_ALARM) begin
                n.owner[i] = drive_cmd_pkg::OWN_GP;
              end
              if (address[5:2] == drive_cmd_pkg::REG_MOTION &&
                  s.owner[i] == drive_cmd_pkg::OWN_MOTION) begin
                n.owner[i] = drive_cmd_pkg::OWN_GP;
              end
            end
            n.owner[wd[2:0] - 3'h1] = (address[5:2] == drive_cmd_pkg::REG_ALARM)
                                    ? drive_cmd_pkg::OWN_ALARM
                                    : drive_cmd_pkg::OWN_MOTION;
            if (s.usage != drive_cmd_pkg::USE_RELEASED && s.brake_pt == wd[2:0]) begin
              n.usage = drive_cmd_pkg::USE_RELEASED;
            end
            n.store = 1'b1;
          end
        end
        drive_cmd_pkg::REG_RATE: begin
          if (rate_ok(wd[2:0])) begin
            n.rate_stored = wd[2:0];
            n.rate_active = wd[2:0];
            n.boot_done = 1'b1;
            n.drop = 1'b1;
            n.store = 1'b1;
          end
        end
        drive_cmd_pkg::REG_QUEUE: begin
          if (wd[drive_cmd_pkg::QUEUE_OVF_BIT]) begin
            n.ovf = 1'b0;
          end
        end
        drive_cmd_pkg::REG_RUN_CUR: begin
          n.run_cur = wd[9:0];
          n.store = 1'b1;
        end
        drive_cmd_pkg::REG_ACC_CUR: begin
          if (wd[9:0] >= s.run_cur) begin
            n.acc_cur = wd[9:0];
            n.acc_rej = 1'b0;
            n.store = 1'b1;
          end else begin
            n.acc_rej = 1'b1;
          end
        end
        drive_cmd_pkg::REG_MODE: begin
          n.mode = wd[4:0];
          n.pm_lang = wd[drive_cmd_pkg::MODE_PM_BIT];
          n.store = 1'b1;
        end
        drive_cmd_pkg::REG_ENABLE: n.en_req = wd[0];
        drive_cmd_pkg::REG_DELAY: begin
          n.rel_dly = wd[15:0];
          n.app_dly = wd[drive_cmd_pkg::DLY_APPLY_LSB +: 16];
          n.store = 1'b1;
        end
        default: n.store = 1'b0;
      endcase
    end

    // stored settings are taken once, the cycle after reset release
    if (!s.loaded) begin
      n.loaded = 1'b1;
      n.pm_lang = nv_pm_lang;
      if (rate_ok(nv_rate_code)) begin
        n.rate_stored = nv_rate_code;
      end
    end

    // boot wait ends when the host answers, the wait runs out or a valid rate is written; of the first two, only expiry with pm_lang set leaves the boot rate
    if (!s.boot_done && s.loaded) begin
      if (host_seen) begin
        n.boot_done = 1'b1;
      end else if (s.boot_cnt == 32'(BOOT_CYCLES - 1)) begin
        n.boot_done = 1'b1;
        if (s.pm_lang) begin
          n.rate_active = n.rate_stored;
          n.drop = 1'b1;
        end
      end else begin
        n.boot_cnt = s.boot_cnt + 32'h1;
      end
    end

    // queue occupancy; a push into a full queue is lost and flagged
    if (queue_push && !push_ok) begin
      n.ovf = 1'b1;
    end
    n.occ = s.occ + {5'h00, push_ok} - {5'h00, queue_pop && s.occ != 6'h00};

    // accel current only counts outside step-direction mode
    n.cur_eff = (s.mode == drive_cmd_pkg::MODE_STEP_DIR) ? s.run_cur : s.acc_cur;

    // millisecond enable for the brake delays
    n.ms_cnt = ms_tick ? 32'h0 : s.ms_cnt + 32'h1;

    // brake timing applies only with an active usage code
    brake_on = (s.usage == drive_cmd_pkg::USE_CLOSED_EN ||
                s.usage == drive_cmd_pkg::USE_OPEN_EN);
    unique case (s.dstate)
      drive_cmd_pkg::DS_OFF: begin
        if (s.en_req) begin
          n.dstate = drive_cmd_pkg::DS_RELEASE;
          n.motor = 1'b1;
          n.dly = brake_on ? s.rel_dly : RST_DLY_ZERO;
        end
      end
      drive_cmd_pkg::DS_RELEASE: begin
        if (!s.en_req) begin
          n.dstate = drive_cmd_pkg::DS_APPLY;
          n.dly = brake_on ? s.app_dly : RST_DLY_ZERO;
        end else if (s.dly == 16'h0000) begin
          n.dstate = drive_cmd_pkg::DS_ON;
          n.move = 1'b1;
        end else if (ms_tick) begin
          n.dly = s.dly - 16'h0001;
        end
      end
      drive_cmd_pkg::DS_ON: begin
        if (!s.en_req) begin
          n.dstate = drive_cmd_pkg::DS_APPLY;
          n.move = 1'b0;
          n.dly = brake_on ? s.app_dly : RST_DLY_ZERO;
        end
      end
      drive_cmd_pkg::DS_APPLY: begin
        // motor current holds until the apply delay has run out
        if (s.dly == 16'h0000) begin
          n.dstate = drive_cmd_pkg::DS_OFF;
          n.motor = 1'b0;
        end else if (ms_tick) begin
          n.dly = s.dly - 16'h0001;
        end
      end
    endcase

    // brake pin follows the enable view, so it engages on the disable itself
    en_view = (n.dstate == drive_cmd_pkg::DS_RELEASE || n.dstate == drive_cmd_pkg::DS_ON);
    for (int i = 0; i < drive_cmd_pkg::IO_POINTS; i++) begin
      n.pin_b[i] = 1'b1;
      if (n.owner[i] == drive_cmd_pkg::OWN_BRAKE && io_is_output[i]) begin
        if (n.usage == drive_cmd_pkg::USE_CLOSED_EN) begin
          n.pin_b[i] = !en_view;
        end else if (n.usage == drive_cmd_pkg::USE_OPEN_EN) begin
          n.pin_b[i] = en_view;
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.usage <= drive_cmd_pkg::USE_RELEASED;
      s.brake_pt <= drive_cmd_pkg::RST_BRAKE_PT;
      s.rate_stored <= drive_cmd_pkg::RATE_BOOT;
      s.rate_active <= drive_cmd_pkg::RATE_BOOT;
      s.run_cur <= drive_cmd_pkg::RST_CURRENT;
      s.acc_cur <= drive_cmd_pkg::RST_CURRENT;
      s.mode <= drive_cmd_pkg::RST_MODE;
      s.rel_dly <= drive_cmd_pkg::RST_DELAY;
      s.app_dly <= drive_cmd_pkg::RST_DELAY;
      s.dstate <= drive_cmd_pkg::DS_OFF;
      s.wait_q <= 1'b1;
      s.pin_b <= 4'hf;
    end else begin
      s <= n;
    end
  end

  // bit clock enable follows the active rate at once
  bit_rate_gen u_bit_rate_gen (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .rate_code(s.rate_active),
    .restart(s.drop),
    .bit_tick(bit_tick)
  );

  assign readdata = s.rdata;
  assign waitrequest = s.wait_q;
  assign nv_store = s.store;
  assign session_drop = s.drop;
  assign out_pin_b = s.pin_b;
  assign motor_on = s.motor;
  assign move_ok = s.move;
  assign accel_cur_eff = s.cur_eff;

endmodule

// ==== dv/drive_cmd_chk_sva.sv ====
`timescale 1ns/1ns
module drive_cmd_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // side outputs
  input wire logic [3:0] io_is_output,
  input wire logic [3:0] out_pin_b,
  input wire logic nv_store,
  input wire logic session_drop,
  input wire logic motor_on,
  input wire logic move_ok
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // --------
  // rate write decode
  // --------
  logic rate_wr;
  logic rate_ok;
  assign rate_wr = write && !waitrequest && address[5:2] == 4'h3 && byteenable[0];
  assign rate_ok = writedata[2:0] >= 3'h1 && writedata[2:0] <= 3'h5;

  // --------
  // assertions
  // --------
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in one cycle");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  ans_cause_a: assert property (!waitrequest |-> $past(read || write))
    else $error("answer without a request");
  rd_hold_a: assert property (waitrequest |-> $stable(readdata))
    else $error("readdata moved outside an answer");
  pin_idle_a: assert property ((io_is_output == 4'h0) [*2] |-> out_pin_b == 4'hf)
    else $error("pin driven on a point that is not an output");
  rate_drop_a: assert property (rate_wr && rate_ok |-> ##[1:2] session_drop)
    else $error("valid rate write kept the session");
  bad_rate_a: assert property (rate_wr && !rate_ok |=> !session_drop [*2])
    else $error("invalid rate code changed the rate");
  rate_store_a: assert property (rate_wr && rate_ok |-> ##[1:2] nv_store)
    else $error("valid rate write not stored");
  drop_pulse_a: assert property (session_drop |=> !session_drop)
    else $error("session drop longer than one cycle");
  move_motor_a: assert property (move_ok |-> motor_on)
    else $error("moves allowed without motor current");
endmodule

// ==== dv/host_model.sv ====
`timescale 1ns/1ns
module host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // bench control
  input wire logic push_go,
  input wire logic pop_go,
  input wire logic [3:0] cfg_out,
  // toward the drive
  output logic queue_push,
  output logic queue_pop,
  output logic [3:0] io_is_output
);
  // one command per cycle while asked; the bench alone decides to overfill
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      queue_push <= 1'b0;
      queue_pop <= 1'b0;
      io_is_output <= 4'h0;
    end else begin
      queue_push <= push_go;
      queue_pop <= pop_go;
      io_is_output <= cfg_out;
    end
  end
endmodule

// ==== dv/drive_cmd_regs_tb_top.sv ====
`timescale 1ns/1ns
module drive_cmd_regs_tb_top;
  // --------
  // stimulus and observation
  // --------
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [2:0] nv_rate_code = 3'h4;
  logic nv_pm_lang = 1'b0;
  logic host_seen = 1'b0;
  logic push_go = 1'b0;
  logic pop_go = 1'b0;
  logic [3:0] cfg_out = 4'h0;
  logic [31:0] readdata;
  logic waitrequest, nv_store, session_drop, bit_tick, queue_push, queue_pop;
  logic [3:0] io_is_output, out_pin_b;
  logic motor_on, move_ok;
  logic [9:0] accel_cur_eff;
  int fail_count = 0;
  int n_tests = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] e, m;

  drive_cmd_regs #(.MS_CYCLES(4), .BOOT_CYCLES(50)) i_dut (.core_clk, .rst_b, .address,
    .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .nv_rate_code,
    .nv_pm_lang, .host_seen, .nv_store, .session_drop, .bit_tick, .queue_push,
    .queue_pop, .io_is_output, .out_pin_b, .motor_on, .move_ok, .accel_cur_eff);
  host_model i_host (.core_clk, .rst_b, .push_go, .pop_go, .cfg_out, .queue_push,
    .queue_pop, .io_is_output);

  // 50 MHz
  always #10 core_clk = ~core_clk;

  // --------
  // shared tasks
  // --------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic rd, input logic [3:0] r, input logic [31:0] d);
    int n;
    n = 0;
    read <= rd;
    write <= !rd;
    address <= {r, 2'b00};
    writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] r, input logic [31:0] d);
    bus(1'b0, r, d);
  endtask

  task automatic rd(input logic [3:0] r, input logic [31:0] x, input logic [31:0] k);
    exp_q.push_back(x & k);
    msk_q.push_back(k);
    bus(1'b1, r, 32'h0);
  endtask

  // compares a value the caller sampled at the falling edge, so the last rising edge has landed
  task automatic pin(input string what, input logic [31:0] seen_now, input logic [31:0] x);
    check(what, seen_now, x);
  endtask

  task automatic wait_motor(input logic v);
    int n;
    for (n = 0; n < 300 && motor_on !== v; n++) @(posedge core_clk);
    if (n >= 300) begin
      fail_count++;
      close_out();
    end
  endtask

  // cycles between two bit clock enables, bounded above the slowest rate
  task automatic tick_gap(output int g);
    int n;
    n = 0;
    g = 0;
    while (bit_tick !== 1'b1 && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    do begin
      @(posedge core_clk);
      g++;
    end while (bit_tick !== 1'b1 && g < 6000);
    if (g >= 6000) begin
      fail_count++;
      close_out();
    end
  endtask

  task automatic do_reset(input logic pm, input logic seen);
    rst_b <= 1'b0;
    nv_pm_lang <= pm;
    host_seen <= seen;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // read answers are compared against the oldest noted expectation
  always @(posedge core_clk) begin
    if (rst_b && read && waitrequest === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check("readdata", readdata & m, e);
    end
  end

  // --------
  // main sequence
  // --------
  initial begin
    logic [2:0] cur;
    logic [1:0] u;
    logic [9:0] r;
    int sh;
    void'($urandom(16));
    // boot: command-language expiry, other mode, host answered
    for (int i = 0; i < 3; i++) begin
      do_reset(i != 1, i == 2);
      rd(drive_cmd_pkg::REG_STATUS, 32'h1, 32'h7);
      repeat (60) @(posedge core_clk);
      rd(drive_cmd_pkg::REG_STATUS, (i == 0) ? 32'h14 : 32'h11, 32'h17);
      if (i == 1) begin
        tick_gap(sh);
        check("boot bit period", 32'(sh), 32'(drive_cmd_pkg::CLK_HZ / 9600));
      end
    end
    rd(drive_cmd_pkg::REG_BRAKE, 32'h13, 32'h73);
    rd(drive_cmd_pkg::REG_QUEUE, 32'h3f, 32'h13f);
    // every rate code, three invalid ones last
    for (int k = 0; k < 8; k++) begin
      if ((k + 1) % 8 != 0 && (k + 1) % 8 <= 5) cur = 3'((k + 1) % 8);
      wr(drive_cmd_pkg::REG_RATE, 32'((k + 1) % 8));
      rd(drive_cmd_pkg::REG_RATE, 32'(cur), 32'h7);
      rd(drive_cmd_pkg::REG_STATUS, 32'(cur), 32'h7);
    end
    // the host must rejoin at the new rate; one bit period proves the switch
    tick_gap(sh);
    check("new bit period", 32'(sh), 32'(drive_cmd_pkg::CLK_HZ / 115200));
    // brake on each point, enable and disable, then claimed away
    cfg_out <= 4'hf;
    wr(drive_cmd_pkg::REG_DELAY, 32'h0003_0002);
    for (int p = 1; p <= 4; p++) begin
      u = (p % 2 == 1) ? 2'h1 : 2'h2;
      sh = 3 * (p - 1);
      wr(drive_cmd_pkg::REG_BRAKE, {25'h0, 3'(p), 2'h0, u});
      rd(drive_cmd_pkg::REG_BRAKE, {25'h0, 3'(p), 2'h0, u}, 32'h73);
      rd(drive_cmd_pkg::REG_OWNER, 32'h2 << sh, 32'h7 << sh);
      @(negedge core_clk);
      pin("pin off", 32'(out_pin_b[p - 1]), 32'(u == 2'h1));
      @(posedge core_clk);
      wr(drive_cmd_pkg::REG_ENABLE, 32'h1);
      wait_motor(1'b1);
      @(negedge core_clk);
      pin("pin on", 32'(out_pin_b[p - 1]), 32'(u == 2'h2));
      @(posedge core_clk);
      wr(drive_cmd_pkg::REG_ENABLE, 32'h0);
      @(negedge core_clk);
      pin("pin apply", 32'(out_pin_b[p - 1]), 32'(u == 2'h1));
      pin("motor held", 32'(motor_on), 32'h1);
      @(posedge core_clk);
      wait_motor(1'b0);
      wr((p % 2 == 1) ? drive_cmd_pkg::REG_ALARM : drive_cmd_pkg::REG_MOTION, 32'(p));
      rd(drive_cmd_pkg::REG_BRAKE, 32'h3, 32'h3);
      rd(drive_cmd_pkg::REG_OWNER, ((p % 2 == 1) ? 32'h1 : 32'h3) << sh, 32'h7 << sh);
    end
    // take over the alarm point, then bad code and bad point are ignored
    wr(drive_cmd_pkg::REG_BRAKE, 32'h31);
    rd(drive_cmd_pkg::REG_OWNER, 32'h80, 32'h1c0);
    wr(drive_cmd_pkg::REG_BRAKE, 32'h10);
    wr(drive_cmd_pkg::REG_BRAKE, 32'h51);
    rd(drive_cmd_pkg::REG_BRAKE, 32'h31, 32'h73);
    wr(drive_cmd_pkg::REG_BRAKE, 32'h33);
    rd(drive_cmd_pkg::REG_OWNER, 32'h0, 32'h1c0);
    // overfill the queue by one, then pop one and clear the flag
    push_go <= 1'b1;
    repeat (64) @(posedge core_clk);
    push_go <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(drive_cmd_pkg::REG_QUEUE, 32'h100, 32'h13f);
    pop_go <= 1'b1;
    @(posedge core_clk);
    pop_go <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(drive_cmd_pkg::REG_QUEUE, 32'h100);
    rd(drive_cmd_pkg::REG_QUEUE, 32'h1, 32'h13f);
    // accel current against running current, then step-direction mode
    r = 10'($urandom_range(900, 1));
    wr(drive_cmd_pkg::REG_RUN_CUR, 32'(r));
    wr(drive_cmd_pkg::REG_ACC_CUR, 32'(r - 10'h1));
    rd(drive_cmd_pkg::REG_ACC_CUR, 32'h0, 32'h3ff);
    rd(drive_cmd_pkg::REG_STATUS, 32'h20, 32'h20);
    wr(drive_cmd_pkg::REG_ACC_CUR, 32'(r));
    rd(drive_cmd_pkg::REG_ACC_CUR, 32'(r), 32'h3ff);
    wr(drive_cmd_pkg::REG_ACC_CUR, 32'(r + 10'h5));
    rd(drive_cmd_pkg::REG_ACC_CUR, 32'(r + 10'h5), 32'h3ff);
    @(negedge core_clk);
    pin("accel eff", 32'(accel_cur_eff), 32'(r + 10'h5));
    @(posedge core_clk);
    wr(drive_cmd_pkg::REG_MODE, 32'h7);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    pin("accel eff mode7", 32'(accel_cur_eff), 32'(r));
    @(posedge core_clk);
    // unmapped word reads zero
    wr(4'hf, $urandom);
    rd(4'hf, 32'h0, 32'hffffffff);
    repeat (4) @(posedge core_clk);
    close_out();
  end
endmodule

bind drive_cmd_regs drive_cmd_chk i_chk (.core_clk, .rst_b, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .io_is_output, .out_pin_b, .nv_store,
  .session_drop, .motor_on, .move_ok);
